// >>> design/tlb_test_pkg.sv
// package: constants, opcode fields and carrier types for the translation test-access block
// assumes: core presents one decoded coprocessor instruction per cycle with its data word
// Behaviour
// - fault/miss bits only valid after match
// - bit24 protection fault, bit23 domain fault
// - miss bit22 set makes faults meaningless
// - phys tag 31:10, size 9:6, zeros
// - phys size codes: F,7,3,0=4KB,1=1KB
// - phys store swaps 4KB/1KB versus tag
// - tag/permission ops indexed by victim pointer
// - phys store uses pipelined last index
// - lockdown writes via c10, op2 0/1
// - lockdown: base, victim, zeros, preserve bit
// - without autoinc, advance after permission write
// - legacy c15,c1,2 selects asynchronous clocking
// - legacy c15,c2,2 selects bus clocked mode
// - legacy c15,c8,2 waits for interrupt
// - autoinc bit advances on tag/permission accesses
// - match miss never starts table walk
// - results latch into 32-bit per-side register
package tlb_test_pkg;
    localparam int IDX_W = 6;
    localparam int ENTRIES = 64;
    localparam int WORD_W = 32;
    // coprocessor number fields
    localparam logic [3:0] CRN_LOCK = 4'hA;
    localparam logic [3:0] CRN_TEST = 4'hF;
    localparam logic [3:0] CRN_CACHE = 4'h7;
    localparam logic [2:0] OP1_TEST = 3'h4;
    localparam logic [2:0] OP1_STD = 3'h0;
    // lockdown word fields
    localparam int LOCK_BASE_LSB = 26;
    localparam int LOCK_VICT_LSB = 20;
    localparam int LOCK_PRES_BIT = 0;
    // tag word fields
    localparam int TAG_LSB = 10;
    localparam int SIZE_LSB = 6;
    localparam int VALID_BIT = 5;
    localparam int PRES_BIT = 4;
    localparam int TAG_W = 22;
    // permission result fields
    localparam int PERM_W = 22;
    localparam int PROT_FAULT_BIT = 24;
    localparam int DOM_FAULT_BIT = 23;
    localparam int MISS_BIT = 22;
    // test status auto-increment bit position
    localparam int AUTOINC_BIT = 3;
    // size encodings
    localparam logic [3:0] PSZ_1M = 4'hF;
    localparam logic [3:0] PSZ_64K = 4'h7;
    localparam logic [3:0] PSZ_16K = 4'h3;
    localparam logic [3:0] PSZ_4K = 4'h0;
    localparam logic [3:0] PSZ_1K = 4'h1;
    localparam logic [3:0] TSZ_4K = 4'h1;
    localparam logic [3:0] TSZ_1K = 4'h0;
    // clocking modes
    typedef enum logic [1:0] {
        CLK_BUS = 2'h1,
        CLK_ASYNC = 2'h2
    } clk_mode_t;
    // one coprocessor instruction from the core
    typedef struct packed {
        logic valid;
        logic is_write;
        logic [2:0] op1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] op2;
        logic [31:0] data;
    } cp_req_t;
    // match compare inputs: access permission check result from outside
    typedef struct packed {
        logic prot_fault;
        logic dom_fault;
    } chk_t;
endpackage

// >>> design/tlb_entry_ram.sv
// file: one translation buffer storage array with registered read data
// assumes: one write and one read port, same clock
`timescale 1ns/1ps
`default_nettype none
module tlb_entry_ram #(
    parameter int DW = 32,
    parameter int AW = 6
) (
    // clock
    input wire logic i_sys_clk,
    // write port
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    // read port
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    // storage has no reset; contents are defined only after a write
    logic [DW-1:0] mem [2**AW];
    // write and registered read
    always_ff @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule
`default_nettype wire

// >>> design/tlb_test_access.sv
// file: test-access logic for both translation buffers (data side 0, instruction side 1)
// assumes: one instruction per cycle, reads answered next cycle; hit check faults from outside
`timescale 1ns/1ps
`default_nettype none
module tlb_test_access (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // coprocessor instruction
    input wire tlb_test_pkg::cp_req_t i_req,
    input wire tlb_test_pkg::chk_t i_chk,
    input wire logic [31:0] i_test_status,
    input wire logic i_irq,
    // answers
    output logic [31:0] o_rdata,
    output logic o_rvalid,
    output tlb_test_pkg::clk_mode_t o_clk_mode,
    output logic o_stall
);
    import tlb_test_pkg::*;

    // decoded fields
    wire is_tst = i_req.valid && i_req.is_write && i_req.op1 == OP1_TEST && i_req.crn == CRN_TEST;
    wire is_std = i_req.valid && i_req.op1 == OP1_STD;
    wire [3:0] m = i_req.crm;
    wire [2:0] o2 = i_req.op2;
    wire autoinc = i_test_status[AUTOINC_BIT];
    // per-side operation strobes, index 0 data, 1 instruction
    // combined writes strobe both
    wire [1:0] tag_wr = {is_tst && o2 == 3'h0 && (m == 4'h5 || m == 4'h7),
                         is_tst && o2 == 3'h0 && (m == 4'h6 || m == 4'h7)};
    wire [1:0] tag_rd = {is_tst && o2 == 3'h4 && m == 4'h5, is_tst && o2 == 3'h4 && m == 4'h6};
    wire [1:0] prm_wr = {is_tst && o2 == 3'h0 && (m == 4'h9 || m == 4'hB),
                         is_tst && o2 == 3'h0 && (m == 4'hA || m == 4'hB)};
    wire [1:0] prm_rd = {is_tst && o2 == 3'h4 && m == 4'h9, is_tst && o2 == 3'h4 && m == 4'hA};
    wire [1:0] phy_wr = {is_tst && o2 == 3'h1 && (m == 4'h1 || m == 4'h3),
                         is_tst && o2 == 3'h1 && (m == 4'h2 || m == 4'h3)};
    wire [1:0] phy_rd = {is_tst && o2 == 3'h5 && m == 4'h1, is_tst && o2 == 3'h5 && m == 4'h2};
    wire [1:0] match = {is_tst && o2 == 3'h4 && m == 4'hD, is_tst && o2 == 3'h4 && m == 4'hE};
    wire [1:0] res_rd = {i_req.valid && !i_req.is_write && i_req.op1 == OP1_TEST &&
                         i_req.crn == CRN_TEST && o2 == 3'h6 && m == 4'h1,
                         i_req.valid && !i_req.is_write && i_req.op1 == OP1_TEST &&
                         i_req.crn == CRN_TEST && o2 == 3'h6 && m == 4'h2};
    wire lk_std = is_std && i_req.crn == CRN_LOCK && m == 4'h0;
    wire [1:0] lk_wr = {lk_std && i_req.is_write && o2 == 3'h1,
                        lk_std && i_req.is_write && o2 == 3'h0};
    wire [1:0] lk_rd = {lk_std && !i_req.is_write && o2 == 3'h1,
                        lk_std && !i_req.is_write && o2 == 3'h0};
    wire leg = is_std && i_req.is_write && i_req.crn == CRN_TEST && o2 == 3'h2;
    wire wfi = (leg && m == 4'h8) ||
               (is_std && i_req.is_write && i_req.crn == CRN_CACHE && m == 4'h0 && o2 == 3'h4);

    // phys store 4KB/1KB swap versus tag encoding
    function automatic logic [3:0] tag_to_phys_size(input logic [3:0] s);
        case (s)
            TSZ_4K: tag_to_phys_size = PSZ_4K;
            TSZ_1K: tag_to_phys_size = PSZ_1K;
            default: tag_to_phys_size = s;
        endcase
    endfunction

    // per-side state
    logic [IDX_W-1:0] base_ff [2];
    logic [IDX_W-1:0] vict_ff [2];
    logic lkp_ff [2];
    logic [IDX_W-1:0] pidx_ff [2];
    logic [31:0] res_ff [2];
    logic [1:0] cap_ff; // which side latches ram data next cycle
    logic [1:0] capsel_ff; // 0 tag, 1 perm, 2 phys, 3 match
    logic [1:0] capside_ff;
    chk_t chk_ff;
    logic [31:0] rdata_ff;
    logic rvalid_ff;
    clk_mode_t mode_ff;
    logic stall_ff;

    genvar s;
    generate
        for (s = 0; s < 2; s++) begin : g_side
            wire [TAG_W+5:0] tag_q;
            wire [PERM_W-1:0] perm_q;
            wire [TAG_W+3:0] phy_q;
            wire [IDX_W-1:0] idx = vict_ff[s];
            // match compares stored valid tag against presented tag; the stored size is not compared
            // stored word drops the four low zero bits, so its fields sit PRES_BIT lower
            wire hit = tag_q[VALID_BIT - PRES_BIT] && tag_q[TAG_W+5:6] == res_ff[s][31:TAG_LSB];
            // tag store holds tag, size, valid, preserve
            tlb_entry_ram #(.DW(TAG_W+6), .AW(IDX_W)) u_tag (
                .i_sys_clk(i_sys_clk),
                .i_we(tag_wr[s]),
                .i_waddr(idx),
                .i_wdata({i_req.data[31:TAG_LSB], i_req.data[9:SIZE_LSB],
                          i_req.data[VALID_BIT], i_req.data[PRES_BIT]}),
                .i_raddr(idx),
                .o_rdata(tag_q)
            );
            tlb_entry_ram #(.DW(PERM_W), .AW(IDX_W)) u_perm (
                .i_sys_clk(i_sys_clk),
                .i_we(prm_wr[s]),
                .i_waddr(idx),
                .i_wdata(i_req.data[PERM_W-1:0]),
                .i_raddr(idx),
                .o_rdata(perm_q)
            );
            tlb_entry_ram #(.DW(TAG_W+4), .AW(IDX_W)) u_phys (
                .i_sys_clk(i_sys_clk),
                .i_we(phy_wr[s]),
                .i_waddr(pidx_ff[s]),
                .i_wdata(i_req.data[31:SIZE_LSB]),
                .i_raddr(pidx_ff[s]),
                .o_rdata(phy_q)
            );
            wire tp_op = tag_wr[s] | tag_rd[s] | prm_wr[s] | prm_rd[s];
            wire adv = autoinc ? tp_op : prm_wr[s];
            wire [IDX_W-1:0] nxt_vict = lk_wr[s] ? i_req.data[LOCK_VICT_LSB +: IDX_W] :
                                        adv ? vict_ff[s] + 1'b1 : vict_ff[s];
            // result word for a match: flags above the permission bits
            wire [31:0] match_word = hit ?
                {7'h00, chk_ff.prot_fault, chk_ff.dom_fault, 1'b0, perm_q} :
                {9'h000, 1'b1, PERM_W'(0)};
            wire [31:0] cap_word = capsel_ff == 2'h0 ? {tag_q[TAG_W+5:6],
                                   tag_q[5:2], tag_q[1], tag_q[0], 4'h0} :
                                   capsel_ff == 2'h1 ? {10'h000, perm_q} :
                                   capsel_ff == 2'h2 ? {phy_q, 6'h00} : match_word;
            // lockdown pointer and result register
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    base_ff[s] <= '0;
                    vict_ff[s] <= '0;
                    lkp_ff[s] <= 1'b0;
                    pidx_ff[s] <= '0;
                    res_ff[s] <= '0;
                end else begin
                    vict_ff[s] <= nxt_vict;
                    if (lk_wr[s]) begin
                        base_ff[s] <= i_req.data[LOCK_BASE_LSB +: IDX_W];
                        lkp_ff[s] <= i_req.data[LOCK_PRES_BIT];
                    end
                    if (tp_op) begin
                        pidx_ff[s] <= idx;
                    end
                    // match key held, then result latched
                    if (match[s]) begin
                        res_ff[s] <= {i_req.data[31:TAG_LSB], 10'h000};
                    end else if (cap_ff[s]) begin
                        res_ff[s] <= cap_word;
                    end
                end
            end
        end
    endgenerate

    // phys result layout with zero low bits (see cap_word)
    wire [1:0] any_rd = tag_rd | prm_rd | phy_rd | match;
    wire [1:0] nxt_capsel = (tag_rd[0] | tag_rd[1]) ? 2'h0 : (prm_rd[0] | prm_rd[1]) ? 2'h1 :
                            (phy_rd[0] | phy_rd[1]) ? 2'h2 : 2'h3;
    wire rd_side = res_rd[1] | lk_rd[1];
    wire [31:0] lk_word = {base_ff[rd_side], vict_ff[rd_side], 19'h00000, lkp_ff[rd_side]};
    // no walk request exists; a miss is only reported

    // capture control, answer register, clock mode and stall
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            cap_ff <= '0;
            capsel_ff <= '0;
            chk_ff <= '0;
            rdata_ff <= '0;
            rvalid_ff <= 1'b0;
            mode_ff <= CLK_BUS;
            stall_ff <= 1'b0;
        end else begin
            cap_ff <= any_rd;
            capsel_ff <= nxt_capsel;
            chk_ff <= i_chk;
            rvalid_ff <= |(res_rd | lk_rd);
            rdata_ff <= (|lk_rd) ? lk_word : res_ff[rd_side];
            if (leg && m == 4'h1) begin
                mode_ff <= CLK_ASYNC;
            end else if (leg && m == 4'h2) begin
                mode_ff <= CLK_BUS;
            end
            // stall until interrupt
            // a wait and an interrupt in one cycle: the wait wins, a held interrupt ends it next
            if (wfi) begin
                stall_ff <= 1'b1;
            end else if (i_irq) begin
                stall_ff <= 1'b0;
            end
        end
    end

    assign o_rdata = rdata_ff;
    assign o_rvalid = rvalid_ff;
    assign o_clk_mode = mode_ff;
    assign o_stall = stall_ff;

    // checks
    AST_PERM_ADV: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (prm_wr[0] && !autoinc && !lk_wr[0]) |=> vict_ff[0] == $past(vict_ff[0]) + 1'b1)
        else $error("victim did not advance after permission write");
    AST_NO_ADV: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (tag_wr[0] && !autoinc && !lk_wr[0] && !prm_wr[0]) |=> $stable(vict_ff[0]))
        else $error("victim moved without autoinc");
    AST_AUTOINC: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (g_side[1].tp_op && autoinc) |=> vict_ff[1] == $past(vict_ff[1]) + 1'b1)
        else $error("autoinc did not advance victim");
    AST_LOCK_LOAD: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        lk_wr[0] |=> vict_ff[0] == $past(i_req.data[LOCK_VICT_LSB +: IDX_W]))
        else $error("lockdown victim not loaded");
    AST_PIDX: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        prm_rd[0] |=> pidx_ff[0] == $past(vict_ff[0]))
        else $error("phys index not pipelined");
    AST_MISS: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (match[0] ##1 !g_side[0].hit) |=> res_ff[0][MISS_BIT])
        else $error("miss not flagged");
    AST_HIT: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (match[0] ##1 g_side[0].hit) |=> !res_ff[0][MISS_BIT] &&
        res_ff[0][PROT_FAULT_BIT] == $past(chk_ff.prot_fault))
        else $error("hit flags wrong");
    AST_ASYNC: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (leg && m == 4'h1) |=> o_clk_mode == CLK_ASYNC)
        else $error("async mode not selected");
    AST_BUS: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (leg && m == 4'h2) |=> o_clk_mode == CLK_BUS)
        else $error("bus mode not selected");
    AST_WFI: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (wfi && !i_irq) |=> o_stall)
        else $error("no stall on wait");
    AST_READ: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        res_rd[0] |=> o_rvalid && o_rdata == $past(res_ff[0]))
        else $error("result read mismatch");
endmodule
`default_nettype wire

// >>> dv/core_irq_model.sv
// file: core-side model that ends a wait-for-interrupt stall with an interrupt
// assumes: stall is a registered level from the block, irq is sampled on the rising edge
`timescale 1ns/1ps
`default_nettype none
module core_irq_model (
    // clock and stall seen from the block
    input wire logic i_sys_clk,
    input wire logic i_stall,
    // cycles to wait before answering, so prompt and slow cores are both tried
    input wire logic [7:0] i_dly,
    // interrupt to the block
    output logic o_irq
);
    int cnt = 0; // cycles spent stalled so far
    initial o_irq = 1'b0;
    always @(posedge i_sys_clk) begin
        cnt <= i_stall ? cnt + 1 : 0;
        // level drops once the stall is gone, a real core would not hold it forever
        o_irq <= i_stall && (cnt >= i_dly);
    end
endmodule
`default_nettype wire

// >>> dv/tlb_test_access_tb_top.sv
// file: self-checking bench for the translation test-access block
// assumes: design answers a result read one cycle after it is taken
`timescale 1ns/1ps
`default_nettype none
module tlb_test_access_tb_top;
    import tlb_test_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    cp_req_t i_req = '0;
    chk_t i_chk = '0;
    logic [31:0] i_test_status = '0;
    logic [7:0] dly = 8'h03; // partner answer delay
    logic i_irq;
    logic [31:0] o_rdata;
    logic o_rvalid;
    clk_mode_t o_clk_mode;
    logic o_stall;
    int errors = 0;
    int checks = 0;
    int seed = 32'he405;
    // bench model: stores by kind (tag, permission, phys), side, index
    logic [31:0] st [3][2][64];
    int vict [2] = '{0, 0};
    int pidx [2] = '{0, 0};
    logic [5:0] lbase [2];
    logic lpres [2];
    localparam logic [3:0] CRM [3][3] = '{'{4'h6, 4'h5, 4'h7}, '{4'hA, 4'h9, 4'hB},
        '{4'h2, 4'h1, 4'h3}};
    localparam logic [31:0] MSK [3] = '{32'hFFFFFFF0, 32'h003FFFFF, 32'hFFFFFFC0};
    logic [31:0] d;
    always #20 i_sys_clk = ~i_sys_clk;
    tlb_test_access tlb_test_access_inst (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
        .i_req(i_req), .i_chk(i_chk), .i_test_status(i_test_status), .i_irq(i_irq),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_clk_mode(o_clk_mode), .o_stall(o_stall));
    core_irq_model core_irq_model_inst (.i_sys_clk(i_sys_clk), .i_stall(o_stall),
        .i_dly(dly), .o_irq(i_irq));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one instruction, valid for exactly one rising edge
    task automatic op(input bit w, input logic [2:0] o1, input logic [3:0] n,
        input logic [3:0] m, input logic [2:0] o2, input logic [31:0] dt);
        @(negedge i_sys_clk);
        i_req <= '{valid: 1'b1, is_write: w, op1: o1, crn: n, crm: m, op2: o2, data: dt};
        @(negedge i_sys_clk);
        i_req.valid <= 1'b0;
    endtask
    // fetch the per-side result word, masked to the bits that carry meaning
    task automatic res(input int s, input logic [31:0] e, input logic [31:0] mk, string nm);
        op(1'b0, OP1_TEST, CRN_TEST, s ? 4'h1 : 4'h2, 3'h6, '0);
        chk("result valid", {31'h0, o_rvalid}, 32'h1);
        chk(nm, o_rdata & mk, e & mk);
    endtask
    // index bookkeeping shared by accesses to the tag and permission stores
    task automatic adv(input int k, input int w, input int i);
        if (k != 2) pidx[i] = vict[i];
        if ((k == 1 && w) || (k != 2 && i_test_status[AUTOINC_BIT])) vict[i] = (vict[i] + 1) % 64;
    endtask
    // k: 0 tag, 1 permission, 2 phys; s: 0 data, 1 instr, 2 both
    task automatic mwr(input int k, input int s, input logic [31:0] dt);
        op(1'b1, OP1_TEST, CRN_TEST, CRM[k][s], (k == 2) ? 3'h1 : 3'h0, dt);
        for (int i = 0; i < 2; i++) begin
            if (s == 2 || s == i) begin
                st[k][i][(k == 2) ? pidx[i] : vict[i]] = dt & MSK[k];
                adv(k, 1, i);
            end
        end
    endtask
    task automatic mrd(input int k, input int s);
        int ix;
        ix = (k == 2) ? pidx[s] : vict[s];
        op(1'b1, OP1_TEST, CRN_TEST, CRM[k][s], (k == 2) ? 3'h5 : 3'h4, '0);
        adv(k, 0, s);
        res(s, st[k][s][ix], MSK[k], "store read");
    endtask
    task automatic lkw(input int s, input logic [5:0] b, input logic [5:0] v, input logic p);
        op(1'b1, OP1_STD, CRN_LOCK, 4'h0, 3'(s), {b, v, 19'h0, p});
        lbase[s] = b;
        vict[s] = v;
        lpres[s] = p;
    endtask
    task automatic lkr(input int s);
        op(1'b0, OP1_STD, CRN_LOCK, 4'h0, 3'(s), '0);
        chk("lock valid", {31'h0, o_rvalid}, 32'h1);
        chk("lockdown", o_rdata, {lbase[s], 6'(vict[s]), 19'h0, lpres[s]});
    endtask
    // compare against the entry under the victim pointer; only a valid entry can hit
    task automatic mmatch(input int s, input logic [21:0] va, input logic p, input logic dm);
        logic [31:0] e;
        logic [31:0] mk;
        e = 32'h00400000;
        mk = 32'h00400000;
        if (st[0][s][vict[s]][VALID_BIT] === 1'b1 && st[0][s][vict[s]][31:10] === va) begin
            e = {7'h0, p, dm, 1'b0, st[1][s][vict[s]][21:0]};
            mk = 32'h01FFFFFF;
        end
        i_chk <= '{prot_fault: p, dom_fault: dm};
        op(1'b1, OP1_TEST, CRN_TEST, s ? 4'hD : 4'hE, 3'h4, {va, 10'h0});
        res(s, e, mk, "match");
    endtask
    // wait op (legacy c15 or c7), stall must be released by the partner in bounded time
    task automatic leg(input logic [3:0] n, input logic [3:0] m, input logic [2:0] o2);
        int k;
        op(1'b1, OP1_STD, n, m, o2, '0);
        chk("stall set", {31'h0, o_stall}, 32'h1);
        k = 0;
        while (o_stall !== 1'b0 && k < 50) begin
            @(negedge i_sys_clk);
            k++;
        end
        chk("stall released", {31'h0, o_stall}, 32'h0);
        if (k == 50) end_sim();
    endtask
    initial begin
        repeat (2) @(negedge i_sys_clk);
        i_srst <= 1'b0;
        chk("reset mode", 32'(o_clk_mode), 32'(CLK_BUS));
        chk("reset stall", {31'h0, o_stall}, 32'h0);
        // clear every tag entry on both sides with auto-increment on
        i_test_status[AUTOINC_BIT] <= 1'b1;
        lkw(0, 6'h0, 6'h0, 1'b0);
        lkw(1, 6'h0, 6'h0, 1'b0);
        for (int i = 0; i < 64; i++) mwr(0, 2, 32'h0);
        lkr(0);
        lkr(1);
        $display("test autoinc_fill done");
        // plain indexing: only a permission write advances the victim
        i_test_status[AUTOINC_BIT] <= 1'b0;
        lkw(0, 6'h19, 6'h19, 1'b1);
        mwr(1, 0, $random(seed));
        lkr(0);
        lkw(0, 6'h19, 6'h19, 1'b0);
        d = $random(seed);
        mwr(0, 0, {d[21:0], TSZ_4K, 1'b1, 1'b1, 4'h0});
        lkr(0);
        mrd(1, 0);
        mrd(0, 0);
        // combined permission write lands on both sides at their own victims
        lkw(1, 6'h0, 6'h28, 1'b0);
        lkw(0, 6'h19, 6'h19, 1'b0);
        mwr(1, 2, $random(seed));
        lkw(0, 6'h19, 6'h19, 1'b0);
        lkw(1, 6'h0, 6'h28, 1'b0);
        mrd(1, 0);
        mrd(1, 1);
        $display("test indexing done");
        // phys store at every size code, with an index switch in between
        foreach (MSK[k]) begin
            d = $random(seed);
            mwr(2, 0, {d[21:0], (k == 0) ? PSZ_1M : (k == 1) ? PSZ_64K : PSZ_16K, 6'h0});
            mrd(2, 0);
        end
        mwr(2, 0, {d[21:0], PSZ_4K, 6'h0});
        lkw(0, 6'h0, 6'h28, 1'b0);
        mwr(1, 0, $random(seed));
        mwr(2, 0, {~d[21:0], PSZ_1K, 6'h0});
        lkw(0, 6'h19, 6'h19, 1'b0);
        mrd(0, 0);
        mrd(2, 0);
        lkw(0, 6'h0, 6'h28, 1'b0);
        mrd(1, 0);
        mrd(2, 0);
        $display("test phys_store done");
        // match hit under each fault pair, then a miss on each side
        lkw(0, 6'h19, 6'h19, 1'b0);
        for (int f = 0; f < 4; f++) mmatch(0, st[0][0][25][31:10], f[1], f[0]);
        mmatch(0, ~st[0][0][25][31:10], 1'b1, 1'b1);
        mmatch(1, st[0][0][25][31:10], 1'b0, 1'b0);
        $display("test match done");
        // legacy clocking and wait ops, slow and prompt partner
        // legacy ops only here
        op(1'b1, OP1_STD, CRN_TEST, 4'h1, 3'h2, '0);
        chk("async mode", 32'(o_clk_mode), 32'(CLK_ASYNC));
        op(1'b1, OP1_STD, CRN_TEST, 4'h2, 3'h2, '0);
        chk("bus mode", 32'(o_clk_mode), 32'(CLK_BUS));
        leg(CRN_TEST, 4'h8, 3'h2);
        dly <= 8'h00;
        leg(CRN_CACHE, 4'h0, 3'h4);
        $display("test legacy done");
        end_sim();
    end
endmodule
`default_nettype wire
